// File: logic/dual_timer_pwm_mode.sv
// Dual 8-bit timer pair with pulse-width, pulse-pattern, wide and dual modes.
// Assumes tick taps arrive as one-cycle enables synchronous to clk, from a prescaler outside.
//
// The register offsets and the Wishbone slave port are this design's own decisions.
`timescale 1ns/1ns
module dual_timer_pwm_mode (
   input  wire logic                     clk,
   input  wire logic                     sys_rst,
   input  wire logic [7:0]               wb_adr_i,
   input  wire logic [31:0]              wb_dat_i,
   output logic      [31:0]              wb_dat_o,
   input  wire logic [3:0]               wb_sel_i,
   input  wire logic                     wb_we_i,
   input  wire logic                     wb_cyc_i,
   input  wire logic                     wb_stb_i,
   output logic                          wb_ack_o,
   input  wire timer_pair_pkg::taps_type taps,
   output logic                          timerOutPin,
   output logic                          lowerMatch,
   output logic                          upperMatch
);
   // Wishbone decode: single-wait answer, ack pulses one cycle.
   logic [7:0] runControlReg, timerPairModeReg, toggleFlopControlReg;
   logic [7:0] lowerCompareReg, lowerBufferReg, upperCompareReg;
   logic [7:0] lowerUpCounterReg, upperCounterReg;
   logic       outputToggleFfReg;
   logic       ackReg;
   logic [31:0] rdataReg;
   wire        busReq   = wb_cyc_i & wb_stb_i & ~ackReg;
   wire        wrStb    = busReq & wb_we_i & wb_sel_i[0];
   wire        wrRun    = wrStb & (wb_adr_i == {4'h0, timer_pair_pkg::ADDR_RUN});
   wire        wrMode   = wrStb & (wb_adr_i == {4'h0, timer_pair_pkg::ADDR_MODE});
   wire        wrFlop   = wrStb & (wb_adr_i == {4'h0, timer_pair_pkg::ADDR_FLOPCTL});
   wire        wrLcmp   = wrStb & (wb_adr_i == {4'h0, timer_pair_pkg::ADDR_LCMP});
   wire        wrUcmp   = wrStb & (wb_adr_i == timer_pair_pkg::BYTE_UCMP);

   // Mode field decode.
   wire timer_pair_pkg::pair_mode_type pairModeSel = timer_pair_pkg::pair_mode_type'(
      timerPairModeReg[timer_pair_pkg::MODE_PAIR_HI:timer_pair_pkg::MODE_PAIR_LO]);
   wire [1:0] wrapCycleSel = timerPairModeReg[timer_pair_pkg::MODE_CYC_HI:timer_pair_pkg::MODE_CYC_LO];
   wire [1:0] upperClkSel  = timerPairModeReg[timer_pair_pkg::MODE_UCLK_HI:timer_pair_pkg::MODE_UCLK_LO];
   wire [1:0] lowerClkSel  = timerPairModeReg[timer_pair_pkg::MODE_LCLK_HI:timer_pair_pkg::MODE_LCLK_LO];
   wire       pwmMode      = (pairModeSel == timer_pair_pkg::PAIR_PWM);
   wire       wideMode     = (pairModeSel == timer_pair_pkg::PAIR_WIDE);
   wire       ppgMode      = (pairModeSel == timer_pair_pkg::PAIR_PPG);
   wire       lowerRun     = runControlReg[timer_pair_pkg::RUN_LOWER];
   wire       upperRun     = runControlReg[timer_pair_pkg::RUN_UPPER];
   wire       dbufEn       = toggleFlopControlReg[timer_pair_pkg::FC_DBUF_EN];
   wire       invEn        = toggleFlopControlReg[timer_pair_pkg::FC_INV_EN];
   wire       toggleSourceSel = toggleFlopControlReg[timer_pair_pkg::FC_SRC_SEL];

   // Wrap limit for the selected cycle; code 00 treated as the full 8-bit span.
   function automatic logic [7:0] wrapLimit(input logic [1:0] code);
      unique case (code)
         2'h1:    wrapLimit = timer_pair_pkg::WRAP_63;
         2'h2:    wrapLimit = timer_pair_pkg::WRAP_127;
         default: wrapLimit = timer_pair_pkg::WRAP_255;
      endcase
   endfunction

   // Tap select for each timer.
   wire lowerTick = (lowerClkSel == 2'h0) ? taps.ext   :
                    (lowerClkSel == 2'h1) ? taps.div1  :
                    (lowerClkSel == 2'h2) ? taps.div4  : taps.div16;
   wire upperTapTick = (upperClkSel == 2'h1) ? taps.div1  :
                       (upperClkSel == 2'h2) ? taps.div16 : taps.div256;
   wire [7:0] limit     = wrapLimit(wrapCycleSel);
   wire       lowerHit  = lowerRun & lowerTick;
   wire       lowerEq   = (lowerUpCounterReg == lowerCompareReg);
   wire       upperEq   = (upperCounterReg == upperCompareReg);
   wire       pwmWrap   = pwmMode & lowerHit & (lowerUpCounterReg == limit);
   wire       pwmMatch  = pwmMode & lowerHit & lowerEq & ~pwmWrap;
   wire       ppgEnd    = ppgMode & lowerHit & (lowerUpCounterReg == upperCompareReg);
   wire       ppgMatch  = ppgMode & lowerHit & lowerEq;
   wire       ivlMatch  = ~pwmMode & ~ppgMode & lowerHit & lowerEq;
   wire       lowerMatchNow = pwmMode ? pwmMatch : (ppgMode ? ppgMatch : ivlMatch);
   wire       upperTick = (upperClkSel == 2'h0 && !pwmMode) ? ivlMatch : upperTapTick;
   wire       upperHit  = upperRun & ~ppgMode & (wideMode ? ivlMatch : upperTick);
   wire       upperFire = upperHit & upperEq & (~wideMode | lowerEq);

   // Toggle event: pulse modes use match and wrap, dual mode follows source select.
   wire       toggleEvt = pwmMode ? (pwmMatch | pwmWrap) :
                          ppgMode ? (ppgMatch | ppgEnd) :
                          wideMode ? upperFire :
                          (toggleSourceSel ? upperFire : ivlMatch);
   wire [1:0] flopCmd   = wb_dat_i[timer_pair_pkg::FC_CMD_HI:timer_pair_pkg::FC_CMD_LO];
   wire       flopCmdGo = wrFlop;

   // Bus registers and read path.
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         ackReg               <= 1'b0;
         rdataReg             <= 32'h0000_0000;
         runControlReg        <= timer_pair_pkg::RUN_RESET;
         timerPairModeReg     <= timer_pair_pkg::MODE_RESET;
         toggleFlopControlReg <= timer_pair_pkg::FLOPCTL_RESET;
         upperCompareReg      <= 8'h00;
      end else begin
         ackReg <= busReq;
         if (wrRun) runControlReg <= wb_dat_i[7:0];
         if (wrMode) timerPairModeReg <= wb_dat_i[7:0];
         if (wrFlop) toggleFlopControlReg <= {wb_dat_i[7:4], 2'h0, wb_dat_i[1:0]};
         if (wrUcmp) upperCompareReg <= wb_dat_i[7:0];
         unique case (wb_adr_i)
            {4'h0, timer_pair_pkg::ADDR_RUN}:     rdataReg <= {24'h0, runControlReg};
            {4'h0, timer_pair_pkg::ADDR_MODE}:    rdataReg <= {24'h0, timerPairModeReg};
            {4'h0, timer_pair_pkg::ADDR_FLOPCTL}: rdataReg <= {24'h0, toggleFlopControlReg};
            {4'h0, timer_pair_pkg::ADDR_LCMP}:    rdataReg <= {24'h0, lowerBufferReg};
            timer_pair_pkg::BYTE_UCMP:            rdataReg <= {24'h0, upperCompareReg};
            timer_pair_pkg::BYTE_STATUS:          rdataReg <= {15'h0, outputToggleFfReg,
                                                      upperCounterReg, lowerUpCounterReg};
            default:                              rdataReg <= 32'h0000_0000;
         endcase
      end
   end
   assign wb_ack_o = ackReg;
   assign wb_dat_o = rdataReg;

   // Compare and buffer: write goes to both when buffering is off, buffer only when on.
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         lowerCompareReg <= 8'h00;
         lowerBufferReg  <= 8'h00;
      end else begin
         if (wrLcmp) lowerBufferReg <= wb_dat_i[7:0];
         if (wrLcmp && !dbufEn) lowerCompareReg <= wb_dat_i[7:0];
         else if (dbufEn && (pwmWrap || ppgEnd)) lowerCompareReg <= lowerBufferReg;
      end
   end

   // Lower up counter: run bit low holds it at zero.
   always_ff @(posedge clk) begin
      if (sys_rst || !lowerRun) lowerUpCounterReg <= 8'h00;
      else if (pwmWrap || ppgEnd) lowerUpCounterReg <= 8'h00;
      else if (ivlMatch && !wideMode) lowerUpCounterReg <= 8'h00;
      else if (ivlMatch && wideMode && upperFire) lowerUpCounterReg <= 8'h00;
      else if (lowerHit) lowerUpCounterReg <= lowerUpCounterReg + 8'h01;
   end

   // Upper counter runs as its own interval timer in dual and pulse-width modes; it does not count in pulse-pattern mode.
   always_ff @(posedge clk) begin
      if (sys_rst || !upperRun) upperCounterReg <= 8'h00;
      else if (upperFire) upperCounterReg <= 8'h00;
      else if (upperHit) upperCounterReg <= upperCounterReg + 8'h01;
   end

   // Output toggle flop: software command wins, otherwise toggles on enabled events.
   always_ff @(posedge clk) begin
      if (sys_rst) outputToggleFfReg <= 1'b0;
      else if (flopCmdGo && flopCmd == timer_pair_pkg::FC_CMD_CLEAR)
         outputToggleFfReg <= 1'b0;
      else if (flopCmdGo && flopCmd == timer_pair_pkg::FC_CMD_SET)
         outputToggleFfReg <= 1'b1;
      else if (flopCmdGo && flopCmd == timer_pair_pkg::FC_CMD_INVERT)
         outputToggleFfReg <= ~outputToggleFfReg;
      else if (invEn && toggleEvt) outputToggleFfReg <= ~outputToggleFfReg;
   end

   // Pin follows the flop; timer output is left to the flop alone.
   assign timerOutPin = outputToggleFfReg;
   assign lowerMatch  = lowerMatchNow;
   assign upperMatch  = upperFire;

   // Checks on the pulse-width path, the run bit, the flop clear command and the bus ack.
   a_wrap_clears: assert property (@(posedge clk) disable iff (sys_rst)
      pwmWrap |=> lowerUpCounterReg == 8'h00) else $error("counter not cleared at wrap");
   a_wrap_toggles: assert property (@(posedge clk) disable iff (sys_rst)
      (pwmWrap && invEn && !wrFlop) |=> timerOutPin != $past(timerOutPin))
      else $error("pin did not toggle at wrap");
   a_match_toggles: assert property (@(posedge clk) disable iff (sys_rst)
      (pwmMatch && invEn && !wrFlop) |=> timerOutPin != $past(timerOutPin))
      else $error("pin did not toggle at match");
   a_buffer_loads: assert property (@(posedge clk) disable iff (sys_rst)
      (pwmWrap && dbufEn && !wrLcmp) |=> lowerCompareReg == $past(lowerBufferReg))
      else $error("buffer not loaded at wrap");
   a_stop_clears: assert property (@(posedge clk) disable iff (sys_rst)
      !lowerRun |=> lowerUpCounterReg == 8'h00) else $error("stopped counter not zero");
   a_count_step: assert property (@(posedge clk) disable iff (sys_rst)
      (pwmMode && lowerHit && !pwmWrap) |=> lowerUpCounterReg == $past(lowerUpCounterReg) + 8'h01)
      else $error("counter did not step");
   a_wrap_limit: assert property (@(posedge clk) disable iff (sys_rst)
      (pwmMode && wrapCycleSel == 2'h2) |-> lowerUpCounterReg <= 8'h7f || $past(!pwmMode))
      else $error("counter passed wrap limit");
   a_flop_clear: assert property (@(posedge clk) disable iff (sys_rst)
      (wrFlop && flopCmd == timer_pair_pkg::FC_CMD_CLEAR) |=> !timerOutPin)
      else $error("flop not cleared");
   a_ack_pulse: assert property (@(posedge clk) disable iff (sys_rst)
      wb_ack_o |=> !wb_ack_o) else $error("ack held longer than one cycle");
endmodule // dual_timer_pwm_mode

// File: common/timer_pair_pkg.sv
// Constants, register map and carried types for the dual timer pair with pulse-width mode.
// Assumes a classic Wishbone slave with 32-bit data words and a single 50 MHz clock.
// What this block does
// - Pulse-width mode only on lower timer, 8-bit.
// - Upper timer still runs as 8-bit timer.
// - Toggle flop drives the timer output pin.
// - Toggle on compare match and on wrap.
// - Counter clears at wrap, not at match.
// - Buffered compare loads at each wrap.
// - Pair-mode codes: 01,00,10,11 decoded.
// - Cycle codes 01,10,11 give 63,127,255.
// - Lower clock: external, div1, div4, div16.
// - Upper clock: lower match (div256 in pulse-width mode), div1, div16, div256.
// - Upper alone in pulse mode: no flop output.
// - Mode register fields at 7:6, 5:4, 3:2, 1:0.
// - Run bit 0 stops and clears lower counter.
// - One control write clears, inverts, buffers.
// - Toggle source select: lower or upper timer.
package timer_pair_pkg;
   localparam logic [3:0] ADDR_RUN     = 4'h0;
   localparam logic [3:0] ADDR_MODE    = 4'h4;
   localparam logic [3:0] ADDR_FLOPCTL = 4'h8;
   localparam logic [3:0] ADDR_LCMP    = 4'hc;
   localparam logic [3:0] ADDR_UCMP    = 4'h0; // Upper compare sits in word 4 (byte 0x10).
   localparam logic [7:0] BYTE_UCMP    = 8'h10;
   localparam logic [7:0] BYTE_STATUS  = 8'h14;
   localparam int MODE_PAIR_HI = 7;
   localparam int MODE_PAIR_LO = 6;
   localparam int MODE_CYC_HI  = 5;
   localparam int MODE_CYC_LO  = 4;
   localparam int MODE_UCLK_HI = 3;
   localparam int MODE_UCLK_LO = 2;
   localparam int MODE_LCLK_HI = 1;
   localparam int MODE_LCLK_LO = 0;
   localparam int FC_INV_EN    = 1;
   localparam int FC_DBUF_EN   = 7;
   localparam int FC_SRC_SEL   = 0;
   localparam int FC_CMD_HI    = 3;
   localparam int FC_CMD_LO    = 2;
   localparam int RUN_LOWER    = 0;
   localparam int RUN_UPPER    = 1;
   localparam logic [7:0] MODE_RESET    = 8'h00;
   localparam logic [7:0] FLOPCTL_RESET = 8'h00;
   localparam logic [7:0] RUN_RESET     = 8'h00;
   localparam logic [7:0] WRAP_63       = 8'h3f;
   localparam logic [7:0] WRAP_127      = 8'h7f;
   localparam logic [7:0] WRAP_255      = 8'hff;
   localparam logic [1:0] FC_CMD_INVERT = 2'h0;
   localparam logic [1:0] FC_CMD_SET    = 2'h1;
   localparam logic [1:0] FC_CMD_CLEAR  = 2'h2;
   typedef enum logic [1:0] {
      PAIR_DUAL8 = 2'h0,
      PAIR_WIDE  = 2'h1,
      PAIR_PPG   = 2'h2,
      PAIR_PWM   = 2'h3
   } pair_mode_type;
   typedef struct packed {
      logic ext;
      logic div1;
      logic div4;
      logic div16;
      logic div256;
   } taps_type;
   typedef struct packed {
      logic [7:0] count;
      logic       match;
      logic       wrap;
   } timer_state_type;
endpackage

// File: test/dual_timer_pwm_mode_tb.sv
// Self-checking bench for the timer pair: a tick-level model is compared at every result.
// Assumes the Wishbone slave answers one cycle after it takes a request, as handed over.
`timescale 1ns/1ns
module dual_timer_pwm_mode_tb;
   logic                     clk = 1'b0;
   logic                     sys_rst = 1'b1;
   logic [7:0]               adr = 8'h00;
   logic [31:0]              datW = 32'h0;
   logic [31:0]              datR;
   logic [3:0]               sel = 4'h0;
   logic                     we = 1'b0;
   logic                     cyc = 1'b0;
   logic                     stb = 1'b0;
   logic                     ack;
   timer_pair_pkg::taps_type taps = '0;
   logic                     pin, lm, um;
   logic [31:0]              q;
   int err_count = 0, samples_checked = 0, cycles = 0;
   int cnt = 0, ucnt = 0, cmpA = 0, cmpB = 0, lim = 0, flop = 0, inv = 0, dbuf = 0, run = 0, lc = 0;
   int c1, c2, ucmp = 0;
   dual_timer_pwm_mode dual_timer_pwm_mode_inst (.clk(clk), .sys_rst(sys_rst), .wb_adr_i(adr),
      .wb_dat_i(datW), .wb_dat_o(datR), .wb_sel_i(sel), .wb_we_i(we), .wb_cyc_i(cyc),
      .wb_stb_i(stb), .wb_ack_o(ack), .taps(taps), .timerOutPin(pin), .lowerMatch(lm),
      .upperMatch(um));
   // Free-running 50 MHz clock.
   always #10 clk = ~clk;
   // Compares one value and counts the comparison.
   task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
      samples_checked++;
      if (got !== exp) begin
         err_count++;
         $display("[FAIL] %s expected %h seen %h", name, exp, got);
      end
   endtask
   // Prints the counts and the verdict, then ends the run.
   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", samples_checked, err_count);
      if (err_count == 0 && samples_checked > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   // One classic Wishbone cycle; the request holds until ack is sampled high or 20 cycles pass.
   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clk);
      cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; datW <= d; sel <= 4'hf;
      do begin
         @(posedge clk);
         n++;
      end while (ack !== 1'b1 && n < 20);
      if (n >= 20) chk("ack", 1, 0);
      q = datR;
      cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
   endtask
   // Reads a register and compares it with the model's value.
   task automatic rd(input string name, input logic [7:0] a, input logic [31:0] exp);
      wb(1'b0, a, 32'h0);
      chk(name, exp, q);
   endtask
   // Pulses the given taps for one cycle, steps the model, then checks the output pin.
   task automatic tick(input logic [4:0] t);
      @(posedge clk) taps <= t;
      @(posedge clk) taps <= '0;
      chk("lowerMatch", (run != 0 && (t & (5'b10000 >> lc)) != 0 && cnt == cmpA && cnt != lim),
         {31'h0, lm});
      chk("upperMatch", ((run & 2) != 0 && (t & 5'b00010) != 0 && ucnt == ucmp),
         {31'h0, um});
      if (run != 0 && (t & (5'b10000 >> lc)) != 0) begin
         if (cnt == lim) begin
            cnt = 0;
            if (inv != 0) flop ^= 1;
            if (dbuf != 0) cmpA = cmpB;
         end else begin
            if (cnt == cmpA && inv != 0) flop ^= 1;
            cnt++;
         end
      end
      if ((run & 2) != 0 && (t & 5'b00010) != 0) ucnt = (ucnt == ucmp) ? 0 : ucnt + 1;
      @(posedge clk);
      chk("timerOutPin", flop[0], {31'h0, pin});
   endtask
   function automatic logic [31:0] status();
      return {15'h0, flop[0], ucnt[7:0], cnt[7:0]};
   endfunction
   // Stops both timers and clears the lower counter; the flop keeps its value.
   task automatic stop_lower();
      wb(1'b1, 8'h00, 32'h0);
      run = 0; cnt = 0;
   endtask
   initial begin
      void'($urandom(32'h2946));
      repeat (6) @(posedge clk);
      sys_rst <= 1'b0;
      rd("mode reset", 8'h04, 32'h0);
      rd("flop control reset", 8'h08, 32'h0);
      rd("run reset", 8'h00, 32'h0);
      rd("unmapped read", 8'h1c, 32'h0);
      $display("test reset done");
      // Cycle codes 1 to 3, a random compare, then a buffered second compare.
      for (int cy = 1; cy <= 3; cy++) begin
         stop_lower();
         lim = (1 << (cy + 5)) - 1;
         lc = 1;
         wb(1'b1, 8'h04, {24'h0, 2'b11, cy[1:0], 2'b00, 2'b01});
         c1 = 1 + $urandom % (lim - 1);
         c2 = 1 + $urandom % (lim - 1);
         wb(1'b1, 8'h08, 32'h0a);
         inv = 1; dbuf = 0; flop = 0;
         wb(1'b1, 8'h0c, c1);
         cmpA = c1; cmpB = c1;
         wb(1'b1, 8'h08, 32'h8a);
         dbuf = 1;
         rd("flop control", 8'h08, 32'h82);
         wb(1'b1, 8'h0c, c2);
         cmpB = c2;
         rd("compare buffer", 8'h0c, c2);
         wb(1'b1, 8'h00, 32'h1);
         run = 1;
         for (int i = 0; i < 2 * (lim + 1) + 3; i++) tick(5'b01000);
         rd("status", 8'h14, status());
         $display("test cycle code %0d done", cy);
      end
      // Each lower clock select counts only its own tap.
      for (int s = 0; s < 4; s++) begin
         lc = s;
         wb(1'b1, 8'h04, {24'h0, 6'b111100, s[1:0]});
         tick(5'b11111 ^ (5'b10000 >> s));
         tick(5'b10000 >> s);
         rd("status clk sel", 8'h14, status());
      end
      $display("test clock select done");
      // Upper timer runs alone beside the pulse-width timer.
      lc = 1;
      wb(1'b1, 8'h04, 32'he9);
      lim = 127;
      wb(1'b1, 8'h10, 32'h03);
      ucmp = 3;
      wb(1'b1, 8'h00, 32'h3);
      run = 3;
      repeat (5) tick(5'b00010);
      rd("status upper", 8'h14, status());
      stop_lower();
      tick(5'b01000);
      rd("status stopped", 8'h14, {15'h0, flop[0], 16'h0});
      $display("test upper and stop done");
      tally_and_finish();
   end
   // Cuts a hang short.
   always @(posedge clk) begin
      cycles++;
      if (cycles == 60000) begin
         err_count++;
         tally_and_finish();
      end
   end
endmodule // dual_timer_pwm_mode_tb
